// File: logic/multibuffer_parallel_spi.sv
// multi-buffered parallel-lane serial master with group queues and request lines
`timescale 1ns/1ps
module multibuffer_parallel_spi (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0][spi_mb_pkg::LEN_W-1:0] fmt_len,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0][spi_mb_pkg::CNT_W-1:0] fmt_prescale,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_cpol,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_cpha,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_no_cs_delay,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_half_duplex,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_lsb_first,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_wait_ena,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_parity_en,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0] fmt_parity_odd,
   input wire logic [spi_mb_pkg::NUM_FMT-1:0][spi_mb_pkg::CNT_W-1:0] fmt_word_delay,
   input wire logic [spi_mb_pkg::CNT_W-1:0] select_to_transfer_delay,
   input wire logic [spi_mb_pkg::CNT_W-1:0] transfer_to_deselect_delay,
   input wire logic [spi_mb_pkg::CNT_W-1:0] ena_timeout,
   input wire logic [spi_mb_pkg::MODE_W-1:0] lane_mode,
   input wire logic [spi_mb_pkg::NUM_GRP-1:0] grp_active,
   input wire logic [spi_mb_pkg::NUM_GRP-1:0][spi_mb_pkg::IDX_W-1:0] grp_first,
   input wire logic [spi_mb_pkg::NUM_GRP-1:0][spi_mb_pkg::IDX_W-1:0] grp_last,
   input wire logic [spi_mb_pkg::NUM_GRP-1:0][spi_mb_pkg::FMT_W-1:0] grp_fmt,
   input wire logic [spi_mb_pkg::NUM_GRP-1:0][spi_mb_pkg::CS_W-1:0] grp_cs,
   input wire logic [spi_mb_pkg::NUM_DMA-1:0] dma_en,
   input wire logic [spi_mb_pkg::NUM_DMA-1:0] dma_on_rx,
   input wire logic [spi_mb_pkg::NUM_DMA-1:0][spi_mb_pkg::IDX_W-1:0] dma_buf,
   input wire logic [spi_mb_pkg::NUM_DMA-1:0][spi_mb_pkg::LINE_W-1:0] dma_line,
   input wire logic buf_wr,
   input wire logic [spi_mb_pkg::ADDR_W-1:0] buf_addr,
   input wire logic [spi_mb_pkg::WORD_W-1:0] buf_wdata,
   input wire logic [spi_mb_pkg::ADDR_W-1:0] buf_raddr,
   output logic [spi_mb_pkg::ENTRY_W-1:0] buf_rdata,
   output logic rx_valid,
   output logic [spi_mb_pkg::DATA_W-1:0] rx_data,
   input wire logic rx_ready,
   output logic sclk,
   output logic [spi_mb_pkg::NUM_CS-1:0] cs_n,
   output logic [spi_mb_pkg::MAX_LANES-1:0] master_out_lane_o,
   output logic [spi_mb_pkg::MAX_LANES-1:0] master_out_lane_oe,
   input wire logic [spi_mb_pkg::MAX_LANES-1:0] master_out_lane_i,
   input wire logic [spi_mb_pkg::MAX_LANES-1:0] slave_out_lane_i,
   input wire logic handshake_enable_line,
   output logic [spi_mb_pkg::NUM_REQ-1:0] dma_req,
   output logic error_event,
   output logic busy
);
   localparam int DW = spi_mb_pkg::DATA_W;
   localparam int LW = spi_mb_pkg::MAX_LANES;
   localparam int MEM_N = 2 * spi_mb_pkg::NUM_BUF;

   function automatic logic [DW-1:0] rev_len(input logic [DW-1:0] d,
                                             input logic [spi_mb_pkg::LEN_W-1:0] len);
      logic [DW-1:0] r;
      r = '0;
      for (int i = 0; i < DW; i++) begin
         if (i < len) r[len-1-i] = d[i];
      end
      return r;
   endfunction : rev_len

   function automatic logic [spi_mb_pkg::PROT_W-1:0] prot(input logic [31:0] w);
      logic [spi_mb_pkg::PROT_W-1:0] p;
      p = '0;
      for (int b = 0; b < spi_mb_pkg::PROT_W; b++) begin
         p[b] = ^w[b*spi_mb_pkg::BYTE_W +: spi_mb_pkg::BYTE_W];
      end
      return p;
   endfunction : prot

   // group lookup, used for host writes and for the queue head
   function automatic logic [spi_mb_pkg::GRP_W:0] grp_of(input logic [spi_mb_pkg::IDX_W-1:0] ix);
      logic [spi_mb_pkg::GRP_W:0] r;
      r = '0;
      for (int g = spi_mb_pkg::NUM_GRP - 1; g >= 0; g--) begin
         if (grp_active[g] && ix >= grp_first[g] && ix <= grp_last[g]) begin
            r = {1'b1, spi_mb_pkg::GRP_W'(g)};
         end
      end
      return r;
   endfunction : grp_of

   // top beat of the shifter, then the shifter advanced by one beat
   function automatic logic [DW+LW-1:0] next_beat(input logic [DW-1:0] sh,
                                                  input logic [3:0] lanes);
      logic [LW-1:0] o;
      o = LW'(sh[DW-1 -: LW] >> (4'(LW) - lanes));
      return {DW'(sh << lanes), o};
   endfunction : next_beat

   // buffer store and queue state
   logic [spi_mb_pkg::ENTRY_W-1:0] mem_r [MEM_N];
   logic [spi_mb_pkg::ENTRY_W-1:0] mem_nxt [MEM_N];
   logic [spi_mb_pkg::NUM_BUF-1:0] pend_r, pend_nxt, pend_clr;
   logic [spi_mb_pkg::ENTRY_W-1:0] rdata_r, rdata_nxt;
   // engine state
   spi_mb_pkg::eng_state_t state_r, state_nxt;
   logic [spi_mb_pkg::IDX_W-1:0] idx_r, idx_nxt;
   logic [spi_mb_pkg::GRP_W-1:0] grp_r, grp_nxt;
   logic [spi_mb_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [spi_mb_pkg::HALF_W-1:0] half_r, half_nxt;
   logic [DW-1:0] sh_r, sh_nxt, rx_r, rx_nxt;
   logic [LW-1:0] out_r, out_nxt, oe_r, oe_nxt;
   logic par_r, par_nxt, prx_r, prx_nxt, read_r, read_nxt, to_r, to_nxt;
   logic sclk_r, sclk_nxt, err_r, err_nxt;
   logic [spi_mb_pkg::NUM_CS-1:0] cs_n_r, cs_n_nxt;
   logic [spi_mb_pkg::NUM_REQ-1:0] dma_r, dma_nxt;
   // two-entry receive stream buffer
   logic [DW-1:0] fifo_r [spi_mb_pkg::FIFO_DEPTH];
   logic [DW-1:0] fifo_nxt [spi_mb_pkg::FIFO_DEPTH];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] fcnt_r, fcnt_nxt;
   logic fifo_room, push, pop;
   // decoded helpers
   logic tx_ev, rx_ev, pick_hit, tick, lead, perr, tx_par;
   logic [spi_mb_pkg::IDX_W-1:0] pick_idx, wr_idx;
   logic [spi_mb_pkg::GRP_W:0] pick_g, wr_g;
   logic [spi_mb_pkg::FMT_W-1:0] f, pf;
   logic [3:0] lanes;
   logic [spi_mb_pkg::LEN_W:0] dbeats, beat, pbeat;
   logic [spi_mb_pkg::HALF_W-1:0] half_end;
   logic [16:0] lmask, pmask;
   logic [DW-1:0] rxw, txw;
   logic [LW-1:0] lane_in;
   logic [spi_mb_pkg::WORD_W-1:0] rxe;

   assign lanes = 4'h1 << lane_mode;
   assign f = grp_fmt[grp_r];
   assign wr_idx = buf_addr[spi_mb_pkg::IDX_LSB +: spi_mb_pkg::IDX_W];
   // group lookup reads the group ports inside the function
   always_comb begin
      wr_g = grp_of(wr_idx);
      pick_g = grp_of(pick_idx);
   end
   assign pf = grp_fmt[pick_g[spi_mb_pkg::GRP_W-1:0]];
   assign lmask = (17'h00001 << fmt_len[f]) - 17'h00001;
   assign pmask = (17'h00001 << fmt_len[pf]) - 17'h00001;
   assign dbeats = (6'(fmt_len[f]) + 6'(lanes) - 6'h01) >> lane_mode;
   assign half_end = {6'(dbeats + 6'(fmt_parity_en[f])), 1'b0};
   assign tick = cnt_r == fmt_prescale[f];
   assign lead = ~half_r[0];
   assign beat = half_r[spi_mb_pkg::HALF_W-1:1];
   assign pbeat = fmt_cpha[f] ? beat : 6'(beat + 6'h01);
   assign lane_in = read_r ? master_out_lane_i : slave_out_lane_i;
   assign fifo_room = fcnt_r != 2'(spi_mb_pkg::FIFO_DEPTH);
   assign txw = mem_r[pick_idx][DW-1:0];
   assign tx_par = ^(txw & pmask[DW-1:0]) ^ fmt_parity_odd[pf];

   // received word: drop trailing pad bits, restore order
   always_comb begin
      logic [DW-1:0] al;
      al = rx_r >> ((8'(dbeats) << lane_mode) - 8'(fmt_len[f]));
      al = al & lmask[DW-1:0];
      rxw = to_r ? '0 : (fmt_lsb_first[f] ? rev_len(al, fmt_len[f]) : al);
      perr = fmt_parity_en[f] & ~to_r & (^rxw ^ prx_r ^ fmt_parity_odd[f]);
      rxe = '0;
      rxe[DW-1:0] = rxw;
      rxe[spi_mb_pkg::ST_PAR_ERR] = perr;
      rxe[spi_mb_pkg::ST_TIMEOUT] = to_r;
   end

   // lowest pending send buffer is the queue head
   always_comb begin
      pick_hit = 1'b0;
      pick_idx = '0;
      for (int i = spi_mb_pkg::NUM_BUF - 1; i >= 0; i--) begin
         if (pend_r[i]) begin
            pick_hit = 1'b1;
            pick_idx = spi_mb_pkg::IDX_W'(i);
         end
      end
   end

   // serial engine
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      grp_nxt = grp_r;
      cnt_nxt = cnt_r;
      half_nxt = half_r;
      sh_nxt = sh_r;
      rx_nxt = rx_r;
      out_nxt = out_r;
      par_nxt = par_r;
      prx_nxt = prx_r;
      read_nxt = read_r;
      to_nxt = to_r;
      sclk_nxt = sclk_r;
      err_nxt = 1'b0;
      tx_ev = 1'b0;
      rx_ev = 1'b0;
      push = 1'b0;
      pend_clr = '0;
      case (state_r)
         spi_mb_pkg::idle: begin
            sclk_nxt = fmt_cpol[f];
            if (pick_hit && !pick_g[spi_mb_pkg::GRP_W]) begin
               pend_clr[pick_idx] = 1'b1;
            end else if (pick_hit) begin
               grp_nxt = pick_g[spi_mb_pkg::GRP_W-1:0];
               idx_nxt = pick_idx;
               pend_clr[pick_idx] = 1'b1;
               tx_ev = 1'b1;
               sh_nxt = DW'((fmt_lsb_first[pf] ? rev_len(txw, fmt_len[pf]) : txw & pmask[DW-1:0])
                            << (5'(DW) - fmt_len[pf]));
               par_nxt = tx_par;
               read_nxt = fmt_half_duplex[pf] & mem_r[pick_idx][spi_mb_pkg::TXC_READ];
               sclk_nxt = fmt_cpol[pf];
               to_nxt = 1'b0;
               rx_nxt = '0;
               cnt_nxt = '0;
               half_nxt = '0;
               state_nxt = spi_mb_pkg::cs_lead;
            end
         end
         spi_mb_pkg::cs_lead: begin
            cnt_nxt = cnt_r + 8'h01;
            if (fmt_no_cs_delay[f] || cnt_r == select_to_transfer_delay) begin
               cnt_nxt = '0;
               state_nxt = fmt_wait_ena[f] ? spi_mb_pkg::await_ena : spi_mb_pkg::shifting;
               if (!fmt_wait_ena[f] && !fmt_cpha[f]) {sh_nxt, out_nxt} = next_beat(sh_r, lanes);
            end
         end
         spi_mb_pkg::await_ena: begin
            cnt_nxt = cnt_r + 8'h01;
            if (handshake_enable_line) begin
               cnt_nxt = '0;
               state_nxt = spi_mb_pkg::shifting;
               if (!fmt_cpha[f]) {sh_nxt, out_nxt} = next_beat(sh_r, lanes);
            end else if (cnt_r == ena_timeout) begin
               to_nxt = 1'b1;
               cnt_nxt = '0;
               state_nxt = spi_mb_pkg::cs_trail;
            end
         end
         spi_mb_pkg::shifting: begin
            cnt_nxt = cnt_r + 8'h01;
            if (tick) begin
               cnt_nxt = '0;
               half_nxt = half_r + 7'h01;
               sclk_nxt = ~sclk_r;
               if (lead ^ fmt_cpha[f]) begin
                  if (beat < dbeats) rx_nxt = DW'(rx_r << lanes) |
                                              DW'(lane_in & ~(8'hff << lanes));
                  else prx_nxt = lane_in[0];
               end
               if ((fmt_cpha[f] ? lead : ~lead) && half_nxt != half_end) begin
                  if (pbeat < dbeats) {sh_nxt, out_nxt} = next_beat(sh_r, lanes);
                  else out_nxt = {7'h00, par_r};
               end
               if (half_nxt == half_end) state_nxt = spi_mb_pkg::cs_trail;
            end
         end
         spi_mb_pkg::cs_trail: begin
            cnt_nxt = cnt_r + 8'h01;
            if (fmt_no_cs_delay[f] || cnt_r == transfer_to_deselect_delay) begin
               cnt_nxt = '0;
               state_nxt = spi_mb_pkg::storing;
            end
         end
         spi_mb_pkg::storing: begin
            if (fifo_room) begin
               rx_ev = 1'b1;
               push = 1'b1;
               err_nxt = perr | to_r;
               state_nxt = spi_mb_pkg::word_gap;
            end
         end
         spi_mb_pkg::word_gap: begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r >= fmt_word_delay[f]) state_nxt = spi_mb_pkg::idle;
         end
         default: state_nxt = spi_mb_pkg::idle;
      endcase
      cs_n_nxt = '1;
      if (state_nxt != spi_mb_pkg::idle && state_nxt != spi_mb_pkg::storing &&
          state_nxt != spi_mb_pkg::word_gap) begin
         cs_n_nxt[grp_cs[grp_nxt]] = 1'b0;
      end
      oe_nxt = ~(8'hff << lanes) & {LW{~read_nxt}};
   end

   // buffer store, pending flags, host read, request lines
   always_comb begin
      mem_nxt = mem_r;
      pend_nxt = pend_r & ~pend_clr;
      if (buf_wr && !buf_addr[spi_mb_pkg::BANK_BIT]) begin
         mem_nxt[{1'b0, wr_idx}] = {prot(buf_wdata), buf_wdata};
         if (wr_g[spi_mb_pkg::GRP_W]) pend_nxt[wr_idx] = 1'b1;
      end
      if (rx_ev) mem_nxt[{1'b1, idx_r}] = {prot(rxe), rxe};
      rdata_nxt = mem_r[buf_raddr[spi_mb_pkg::IDX_LSB +: spi_mb_pkg::IDX_W + 1]];
      dma_nxt = '0;
      for (int c = 0; c < spi_mb_pkg::NUM_DMA; c++) begin
         if (dma_en[c] && (dma_on_rx[c] ? rx_ev && dma_buf[c] == idx_r
                                         : tx_ev && dma_buf[c] == pick_idx)) begin
            dma_nxt[dma_line[c]] = 1'b1;
         end
      end
   end

   // receive stream buffer; a full buffer holds the engine in storing
   assign pop = rx_valid & rx_ready;
   always_comb begin
      fifo_nxt = fifo_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (push) begin
         fifo_nxt[wp_r] = rxw;
         wp_nxt = ~wp_r;
      end
      if (pop) rp_nxt = ~rp_r;
      fcnt_nxt = fcnt_r + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < MEM_N; i++) mem_r[i] <= '0;
         pend_r <= '0;
         rdata_r <= '0;
         dma_r <= '0;
         fifo_r <= '{default: '0};
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         fcnt_r <= '0;
      end else if (clk_en) begin
         mem_r <= mem_nxt;
         pend_r <= pend_nxt;
         rdata_r <= rdata_nxt;
         dma_r <= dma_nxt;
         fifo_r <= fifo_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         fcnt_r <= fcnt_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= spi_mb_pkg::idle;
         idx_r <= '0;
         grp_r <= '0;
         cnt_r <= '0;
         half_r <= '0;
         sh_r <= '0;
         rx_r <= '0;
         out_r <= '0;
         oe_r <= '0;
         par_r <= 1'b0;
         prx_r <= 1'b0;
         read_r <= 1'b0;
         to_r <= 1'b0;
         sclk_r <= 1'b0;
         err_r <= 1'b0;
         cs_n_r <= '1;
      end else if (clk_en) begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         grp_r <= grp_nxt;
         cnt_r <= cnt_nxt;
         half_r <= half_nxt;
         sh_r <= sh_nxt;
         rx_r <= rx_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         par_r <= par_nxt;
         prx_r <= prx_nxt;
         read_r <= read_nxt;
         to_r <= to_nxt;
         sclk_r <= sclk_nxt;
         err_r <= err_nxt;
         cs_n_r <= cs_n_nxt;
      end
   end

   assign buf_rdata = rdata_r;
   assign rx_valid = fcnt_r != 2'h0;
   assign rx_data = fifo_r[rp_r];
   assign sclk = sclk_r;
   assign cs_n = cs_n_r;
   assign master_out_lane_o = out_r;
   assign master_out_lane_oe = oe_r;
   assign dma_req = dma_r;
   assign error_event = err_r;
   assign busy = state_r != spi_mb_pkg::idle;

   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || !clk_en);

   a_cs_while_shift: assert property (
      state_r == spi_mb_pkg::shifting |-> cs_n_r != '1)
      else $error("select released during shifting");
   a_hs_gate_start: assert property (
      (state_r == spi_mb_pkg::shifting && $past(state_r) == spi_mb_pkg::await_ena)
      |-> $past(handshake_enable_line))
      else $error("word started without enable");
   a_ena_timeout: assert property (
      (state_r == spi_mb_pkg::await_ena && !handshake_enable_line && cnt_r == ena_timeout)
      ##1 clk_en |-> state_r == spi_mb_pkg::cs_trail && to_r)
      else $error("handshake timeout not taken");
   a_err_flag_out: assert property (
      (state_r == spi_mb_pkg::storing && fifo_room && to_r) |=> error_event)
      else $error("timeout not flagged");
   a_dma_rx_fire: assert property (
      (rx_ev && dma_en[0] && dma_on_rx[0] && dma_buf[0] == idx_r) |=> dma_req[$past(dma_line[0])])
      else $error("receive request missing");
   a_sclk_rest: assert property (
      state_r == spi_mb_pkg::cs_trail && !to_r |-> sclk_r == fmt_cpol[f])
      else $error("clock not at idle polarity");
   a_par_beat: assert property (
      (state_r == spi_mb_pkg::shifting && fmt_parity_en[f] && half_r == half_end - 7'h01)
      |-> out_r == {7'h00, par_r})
      else $error("parity beat wrong");
   a_half_dup_oe: assert property (
      (read_r && state_r == spi_mb_pkg::shifting) |-> master_out_lane_oe == '0)
      else $error("lanes driven while reading");
   a_start_write: assert property (
      (state_r == spi_mb_pkg::idle && pick_hit && pick_g[spi_mb_pkg::GRP_W])
      |=> state_r == spi_mb_pkg::cs_lead)
      else $error("queued word not started");
   a_gap_hold: assert property (
      (state_r == spi_mb_pkg::word_gap && cnt_r < fmt_word_delay[f])
      |=> state_r == spi_mb_pkg::word_gap)
      else $error("word gap cut short");
   a_half_bound: assert property (
      state_r == spi_mb_pkg::shifting |-> half_r < half_end)
      else $error("too many clock halves");
endmodule : multibuffer_parallel_spi

// File: logic/spi_mb_pkg.sv
// constants and types for the multi-buffered parallel-lane serial port
// How it works
// - four word formats exist; each transfer group picks one of them
// - every format sets a word length between 2 and 16 bits
// - a per-format prescaler divides the clock to make the serial rate as master
// - each format picks clock polarity and phase; both ends must agree
// - as master, delays surround select assertion; a format bit can skip them
// - a half-duplex format bit lets the read bit (16) of a send word turn the data lanes to receive
// - msb or lsb first; the msb sits at the top of the word length
// - with handshake on, no word starts until the enable line is high
// - while waiting for enable a timeout counter catches a silent slave
// - optional odd or even parity follows the word and is checked on receive
// - each format sets an idle gap between consecutive words
// - one, two, four or eight lanes each way; both ends use the same count
// - with parity, an extra beat carries the parity bit on lane 0
// - the buffer store holds send and receive queues split into eight groups
// - equal send and receive banks of 128 four-byte buffers each
// - data in bits 15..0, status above, protection 35..32; receive bank at 0x200
// - a mapped request fires after a send buffer is read or receive buffer written
// - sixteen request lines; any of eight buffer channels routes to any line
// - a word starts once a send buffer of an active group is written and the engine is idle; the lowest pending buffer goes first
package spi_mb_pkg;
   localparam int NUM_FMT = 4;
   localparam int NUM_GRP = 8;
   localparam int NUM_BUF = 128;
   localparam int NUM_DMA = 8;
   localparam int NUM_REQ = 16;
   localparam int MAX_LANES = 8;
   localparam int NUM_CS = 8;
   localparam logic [4:0] MIN_LEN = 5'h02;
   localparam logic [4:0] MAX_LEN = 5'h10;
   localparam int LEN_W = 5;
   localparam int CNT_W = 8;
   localparam int IDX_W = 7;
   localparam int GRP_W = 3;
   localparam int FMT_W = 2;
   localparam int CS_W = 3;
   localparam int LINE_W = 4;
   localparam int MODE_W = 2;
   localparam int DATA_W = 16;
   localparam int WORD_W = 32;
   localparam int PROT_W = 4;
   localparam int BYTE_W = 8;
   localparam int ENTRY_W = 36;
   localparam int ADDR_W = 10;
   localparam int HALF_W = 7;
   // byte address layout: bank bit selects receive, index above the word offset
   localparam logic [ADDR_W-1:0] TX_BASE = 10'h000;
   localparam logic [ADDR_W-1:0] TX_LAST = 10'h1fc;
   localparam logic [ADDR_W-1:0] RX_BASE = 10'h200;
   localparam int IDX_LSB = 2;
   localparam int BANK_BIT = 9;
   // status and control field positions
   localparam int ST_PAR_ERR = 16;
   localparam int ST_TIMEOUT = 17;
   localparam int TXC_READ = 16;
   localparam int FIFO_DEPTH = 2;
   typedef enum logic [2:0] {
      idle, cs_lead, await_ena, shifting, cs_trail, storing, word_gap
   } eng_state_t;
endpackage : spi_mb_pkg

// File: dv/spi_far_slave.sv
// far-side serial slave model: one lane, clock mode 0, optional handshake
`timescale 1ns/1ps
module spi_far_slave #(parameter logic [15:0] REPLY = 16'ha5c3) (
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic [7:0] mo_lane,
   input wire logic go,
   output logic [7:0] so_lane,
   output logic ena,
   output logic [15:0] got
);
   logic [15:0] tx_sr = 16'h0000;
   initial got = 16'h0000;
   // reply loaded as select falls so the first bit leads the first edge
   always @(negedge sel_n) tx_sr = REPLY;
   always @(negedge sclk) if (!sel_n) tx_sr = {tx_sr[14:0], 1'b0};
   always @(posedge sclk) if (!sel_n) got = {got[14:0], mo_lane[0]};
   // released lanes all show the inverse of the top reply bit
   assign so_lane = sel_n ? {8{~tx_sr[15]}} : {7'h00, tx_sr[15]};
   assign ena = go;
endmodule : spi_far_slave

// File: dv/tb.sv
// self-checking bench for the multi-buffered serial master
`timescale 1ns/1ps
module tb;
   logic clock, sys_rst, buf_wr, rx_ready, ena_go;
   logic [9:0] buf_addr, buf_raddr;
   logic [31:0] buf_wdata;
   logic [35:0] buf_rdata, rd_v;
   logic rx_valid, sclk, err_ev, busy, ena;
   logic [15:0] rx_data, far_got;
   logic [7:0] cs_n, mo_o, mo_oe, mo_w, so_w;
   logic [15:0] dma_req;
   int mismatches = 0, checked = 0, cyc = 0, err_n = 0, d3 = 0, d5 = 0;
   logic ce = 1'b1;
   logic [1:0] lmode = 2'h0;
   logic [3:0] f_cpol = 4'h0, f_cpha = 4'h0, f_nocs = 4'h0, f_hd = 4'h0, f_lsb = 4'h0;
   logic [3:0] f_wait = 4'h2, f_par = 4'h0, f_odd = 4'h0;
   logic [19:0] f_len = {4{5'h10}};
   logic [31:0] f_pre = {4{8'h01}}, f_gap = {4{8'h01}};
   logic [7:0] lead_d = 8'h02, trail_d = 8'h02, ena_to = 8'h04, g_act = 8'h03;
   logic [7:0] d_en = 8'h03, d_rx = 8'h02;
   logic [55:0] d_buf = 56'h0;
   multibuffer_parallel_spi DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(ce),
      .fmt_len(f_len), .fmt_prescale(f_pre), .fmt_cpol(f_cpol), .fmt_cpha(f_cpha),
      .fmt_no_cs_delay(f_nocs), .fmt_half_duplex(f_hd), .fmt_lsb_first(f_lsb),
      .fmt_wait_ena(f_wait), .fmt_parity_en(f_par), .fmt_parity_odd(f_odd),
      .fmt_word_delay(f_gap), .select_to_transfer_delay(lead_d),
      .transfer_to_deselect_delay(trail_d), .ena_timeout(ena_to), .lane_mode(lmode),
      .grp_active(g_act), .grp_first({{6{7'h00}}, 7'h01, 7'h00}),
      .grp_last({{6{7'h00}}, 7'h01, 7'h00}), .grp_fmt({{6{2'h0}}, 2'h1, 2'h0}),
      .grp_cs({{6{3'h0}}, 3'h1, 3'h0}), .dma_en(d_en), .dma_on_rx(d_rx),
      .dma_buf(d_buf), .dma_line({{6{4'h0}}, 4'h5, 4'h3}), .buf_wr(buf_wr),
      .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_raddr(buf_raddr),
      .buf_rdata(buf_rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .sclk(sclk), .cs_n(cs_n), .master_out_lane_o(mo_o), .master_out_lane_oe(mo_oe),
      .master_out_lane_i(mo_w), .slave_out_lane_i(so_w), .handshake_enable_line(ena),
      .dma_req(dma_req), .error_event(err_ev), .busy(busy));
   assign mo_w = mo_o & mo_oe;
   spi_far_slave far (.sclk(sclk), .sel_n(&cs_n), .mo_lane(mo_w), .go(ena_go),
      .so_lane(so_w), .ena(ena), .got(far_got));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (err_ev === 1'b1) err_n++;
      if (dma_req[3] === 1'b1) d3++;
      if (dma_req[5] === 1'b1) d5++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(negedge clock);
      buf_wr = 1'b1;
      buf_addr = a;
      buf_wdata = d;
      @(negedge clock);
      buf_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] a);
      @(negedge clock);
      buf_raddr = a;
      @(negedge clock);
      rd_v = buf_rdata;
   endtask : rd
   task automatic run_word();
      int n;
      for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge clock);
      chk("busy start", 36'h1, {35'h0, busy});
      for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clock);
      chk("busy end", 36'h0, {35'h0, busy});
   endtask : run_word
   task automatic pop(input logic [15:0] exp);
      int n;
      for (n = 0; n < 20 && rx_valid !== 1'b1; n++) @(negedge clock);
      chk("rx_data", {20'h0, exp}, {20'h0, rx_data});
      rx_ready = 1'b1;
      @(negedge clock);
      rx_ready = 1'b0;
   endtask : pop
   function automatic logic [35:0] ent(input logic [31:0] w);
      return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0], w};
   endfunction : ent
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   initial begin
      sys_rst = 1'b1;
      buf_wr = 1'b0;
      rx_ready = 1'b0;
      ena_go = 1'b0;
      buf_addr = 10'h000;
      buf_raddr = 10'h000;
      buf_wdata = 32'h0;
      repeat (16) @(negedge clock);
      chk("cs_n reset", 36'hff, {28'h0, cs_n});
      sys_rst = 1'b0;
      rd(10'h000);
      chk("tx entry reset", 36'h0, rd_v);
      wr(10'h000, 32'h0000_3c96);
      run_word();
      pop(16'ha5c3);
      chk("far got", 36'h3c96, {20'h0, far_got});
      rd(10'h000);
      chk("tx entry", ent(32'h0000_3c96), rd_v);
      rd(10'h200);
      chk("rx entry", 36'h0a5c3, {18'h0, rd_v[17:0]});
      chk("tx request", 36'h1, d3);
      chk("rx request", 36'h1, d5);
      $display("test basic word done");
      wr(10'h204, 32'h0000_ffff);
      rd(10'h204);
      chk("rx bank write", 36'h0, rd_v);
      $display("test refused write done");
      wr(10'h004, 32'h0000_1234);
      run_word();
      pop(16'h0000);
      rd(10'h204);
      chk("timeout status", 36'h20000, {18'h0, rd_v[17:0]});
      chk("error event", 36'h1, err_n);
      $display("test handshake timeout done");
      ena_go = 1'b1;
      wr(10'h004, 32'h0000_5a5a);
      run_word();
      pop(16'ha5c3);
      rd(10'h204);
      chk("handshake status", 36'h0a5c3, {18'h0, rd_v[17:0]});
      chk("far got hs", 36'h5a5a, {20'h0, far_got});
      $display("test handshake done");
      f_par = 4'h1;
      f_odd = 4'h1;
      f_lsb = 4'h1;
      wr(10'h000, 32'h0000_3c96);
      run_word();
      pop(16'hc3a5);
      chk("far got par", 36'hd279, {20'h0, far_got});
      rd(10'h200);
      chk("parity status", 36'h1c3a5, {18'h0, rd_v[17:0]});
      chk("parity event", 36'h2, err_n);
      $display("test parity lsb done");
      f_par = 4'h0;
      f_lsb = 4'h0;
      f_hd = 4'h1;
      ce = 1'b0;
      wr(10'h000, 32'h0001_3c96);
      @(negedge clock);
      chk("frozen busy", 36'h0, {35'h0, busy});
      ce = 1'b1;
      wr(10'h000, 32'h0001_3c96);
      run_word();
      pop(16'h0000);
      chk("far got hd", 36'h0, {20'h0, far_got});
      $display("test half duplex done");
      give_verdict();
   end
endmodule : tb
